// file: testbench/pwmct_chk.sv
`timescale 1ns/1ps
// Watches channel one and the low pair, which the bench exercises hardest.
module pwmct_chk (
    input wire logic                    clock_i,
    input wire logic                    rst_n_i,
    input wire pwmct_pkg::pwmct_ticks_t ticks_i,
    input wire pwmct_pkg::pwmct_ctrl_t  ctrl_i,
    input wire pwmct_pkg::pwmct_join_t  join_i,
    input wire pwmct_pkg::pwmct_wr_t    wr_i,
    input wire logic [5:0][7:0]         channel_counter_o,
    input wire logic [5:0]              pwm_o
);
    logic        tick1;   // Tick that feeds channel one.
    logic [15:0] wide01;  // Joined count of the low pair.
    assign tick1  = ctrl_i.clock_choice_bit[1] ? ticks_i.clk_sa : ticks_i.clk_a;
    assign wide01 = {channel_counter_o[0], channel_counter_o[1]};
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_wr_clears: assert property (wr_i.counter_wr[1] && !join_i.join_pair_low
        |-> ##2 channel_counter_o[1] == 8'h00) else $error("count not cleared by write");
    chk_join_clear: assert property (wr_i.counter_wr[0] && join_i.join_pair_low
        |-> ##2 wide01 == 16'h0000) else $error("joined count not cleared");
    chk_step_one: assert property (!join_i.join_pair_low && !$past(join_i.join_pair_low, 2)
        && $changed(channel_counter_o[1]) |-> channel_counter_o[1] == 8'h00
        || channel_counter_o[1] == $past(channel_counter_o[1]) + 8'h01
        || channel_counter_o[1] == $past(channel_counter_o[1]) - 8'h01)
        else $error("count jumped");
    chk_need_cause: assert property ($changed(channel_counter_o[1]) |-> $past(tick1, 2)
        || $past(wr_i.counter_wr[1], 2) || $past(wr_i.counter_wr[0], 2))
        else $error("count moved without tick or write");
    chk_hold_off: assert property (!join_i.join_pair_low
        && $past(!ctrl_i.channel_enable_bit[1], 2) && $past(!wr_i.counter_wr[1], 2)
        |-> $stable(channel_counter_o[1]) || channel_counter_o[1] == 8'h00)
        else $error("disabled count moved");
    chk_zero_up: assert property ((!join_i.join_pair_low && channel_counter_o[1] == 8'h00)
        ##1 channel_counter_o[1] != 8'h00 |-> channel_counter_o[1] == 8'h01)
        else $error("count left zero downward");
    chk_even_off: assert property (join_i.join_pair_low [*3] |-> !pwm_o[0])
        else $error("even pin driven while joined");
    chk_wide_step: assert property (join_i.join_pair_low && $past(join_i.join_pair_low, 2)
        && $changed(wide01) |-> wide01 == 16'h0000 || wide01 == $past(wide01) + 16'h0001
        || wide01 == $past(wide01) - 16'h0001) else $error("joined count jumped");
endmodule // pwmct_chk

bind pwmct_top pwmct_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .ticks_i(ticks_i),
    .ctrl_i(ctrl_i), .join_i(join_i), .wr_i(wr_i), .channel_counter_o(channel_counter_o),
    .pwm_o(pwm_o));

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic                    clock_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    pwmct_pkg::pwmct_ticks_t ticks_i = '0;
    pwmct_pkg::pwmct_ctrl_t  ctrl_i  = '0;
    pwmct_pkg::pwmct_join_t  join_i  = '0;
    pwmct_pkg::pwmct_wr_t    wr_i    = '0;
    logic [5:0][7:0]         channel_counter_o;
    logic [5:0]              pwm_o;
    int                      err_count   = 0;
    int                      check_count = 0;
    int hi, ev, zr;        // Results of the last measurement.
    logic [15:0] mx;       // Highest count seen in the last measurement.
    always #2.5 clock_i = ~clock_i;
    pwmct_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ticks_i(ticks_i), .ctrl_i(ctrl_i),
        .join_i(join_i), .wr_i(wr_i), .channel_counter_o(channel_counter_o), .pwm_o(pwm_o));
    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compares one value and counts the comparison.
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One write strobe: kind 0 period, 1 duty, other counter.
    task automatic wr(input int kind, input int ch, input logic [7:0] val);
        @(posedge clock_i);
        wr_i.data <= val;
        case (kind)
            0: wr_i.period_wr[ch] <= 1'b1;
            1: wr_i.duty_wr[ch] <= 1'b1;
            default: wr_i.counter_wr[ch] <= 1'b1;
        endcase
        @(posedge clock_i);
        wr_i <= '0;
    endtask
    // Waits, bounded, until a byte counter shows a value.
    task automatic wait_val(input int ch, input logic [7:0] v);
        for (int i = 0; i < 600; i++) begin
            @(posedge clock_i);
            #1;
            if (channel_counter_o[ch] === v) return;
        end
        err_count++;
        final_report();
    endtask
    // Loads values while disabled, so they go straight to the active copies.
    task automatic setup(input int ch, input logic [7:0] per, input logic [7:0] dt,
                         input logic pol, input logic ctr);
        @(posedge clock_i);
        ctrl_i.channel_enable_bit[ch] <= 1'b0;
        ctrl_i.polarity_bit[ch] <= pol;
        ctrl_i.center_align_bit[ch] <= ctr;
        wr(0, ch, per);
        wr(1, ch, dt);
        wr(2, ch, 8'h00);
        @(posedge clock_i);
        ctrl_i.channel_enable_bit[ch] <= 1'b1;
        repeat (12) @(posedge clock_i);
    endtask
    // Counts pin highs, even pin highs and zero counts over whole periods.
    task automatic measure(input int ch, input logic wide, input int n);
        logic [15:0] v;
        hi = 0;
        ev = 0;
        zr = 0;
        mx = '0;
        repeat (n) begin
            @(posedge clock_i);
            #1;
            v = wide ? {channel_counter_o[ch-1], channel_counter_o[ch]}
                     : {8'h00, channel_counter_o[ch]};
            hi += int'(pwm_o[ch] === 1'b1);
            ev += int'(pwm_o[ch-1] === 1'b1);
            zr += int'(v === 16'h0000);
            if (v > mx) mx = v;
        end
    endtask
    // Left aligned, both polarities, period four and duty one.
    task automatic t_left();
        setup(1, 8'h04, 8'h01, 1'b0, 1'b0);
        measure(1, 1'b0, 40);
        chk("left high", 16'd30, 16'(hi));
        chk("left zeros", 16'd10, 16'(zr));
        chk("left max", 16'd3, mx);
        setup(1, 8'h04, 8'h01, 1'b1, 1'b0);
        measure(1, 1'b0, 40);
        chk("left pol high", 16'd10, 16'(hi));
    endtask
    // Center aligned, then a counter write while enabled and stalled.
    task automatic t_center();
        setup(1, 8'h04, 8'h01, 1'b0, 1'b1);
        measure(1, 1'b0, 80);
        chk("center high", 16'd60, 16'(hi));
        chk("center zeros", 16'd10, 16'(zr));
        chk("center max", 16'd4, mx);
        wait_val(1, 8'h04);
        @(posedge clock_i);
        ticks_i.clk_a <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        chk("pin before write", 16'd1, 16'(pwm_o[1]));
        wr(2, 1, 8'hA5);
        repeat (3) @(posedge clock_i);
        #1;
        chk("count after write", 16'h0000, 16'(channel_counter_o[1]));
        chk("pin after write", 16'd0, 16'(pwm_o[1]));
        @(posedge clock_i);
        ticks_i.clk_a <= 1'b1;
    endtask
    // Boundary values of period and duty, left aligned.
    task automatic t_bound();
        logic [7:0] pr[4] = '{8'h04, 8'h00, 8'h04, 8'h04};
        logic [7:0] dt[4] = '{8'h00, 8'h02, 8'h05, 8'h04};
        logic       pl[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        int         ex[4] = '{40, 40, 0, 40};
        for (int k = 0; k < 4; k++) begin
            setup(1, pr[k], dt[k], pl[k], 1'b0);
            measure(1, 1'b0, 40);
            chk("boundary high", 16'(ex[k]), 16'(hi));
            if (k == 1) begin
                chk("zero period count", 16'd40, 16'(zr));
            end
        end
    endtask
    // Channel three sits on the B group: clock A ticks must not move it.
    task automatic t_group();
        setup(3, 8'h04, 8'h01, 1'b0, 1'b0);
        measure(3, 1'b0, 40);
        chk("group b idle zeros", 16'd40, 16'(zr));
        @(posedge clock_i);
        ticks_i.clk_b <= 1'b1;
        repeat (4) @(posedge clock_i);
        measure(3, 1'b0, 40);
        chk("group b high", 16'd30, 16'(hi));
        @(posedge clock_i);
        ticks_i.clk_b <= 1'b0;
    endtask
    // Disable holds, enable resumes, zero period clears a disabled count.
    task automatic t_hold();
        logic [7:0] held;
        setup(1, 8'h04, 8'h01, 1'b0, 1'b0);
        wait_val(1, 8'h02);
        @(posedge clock_i);
        ctrl_i.channel_enable_bit[1] <= 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        held = channel_counter_o[1];
        repeat (10) @(posedge clock_i);
        #1;
        chk("held count", 16'(held), 16'(channel_counter_o[1]));
        @(posedge clock_i);
        ctrl_i.channel_enable_bit[1] <= 1'b1;
        for (int i = 0; i < 20 && channel_counter_o[1] === held; i++) begin
            @(posedge clock_i);
            #1;
        end
        chk("resumed count", 16'((held + 8'h01) % 8'h04), 16'(channel_counter_o[1]));
        wait_val(1, 8'h02);
        @(posedge clock_i);
        ctrl_i.channel_enable_bit[1] <= 1'b0;
        wr(0, 1, 8'h00);
        repeat (4) @(posedge clock_i);
        #1;
        chk("zero period clear", 16'h0000, 16'(channel_counter_o[1]));
    endtask
    // Joined low pair; even enable and alignment set but without effect.
    task automatic t_join();
        @(posedge clock_i);
        join_i.join_pair_low <= 1'b1;
        ctrl_i.channel_enable_bit[0] <= 1'b1;
        ctrl_i.center_align_bit[0] <= 1'b1;
        ctrl_i.polarity_bit[0] <= 1'b0;
        wr(0, 0, 8'h01);
        wr(0, 1, 8'h02);
        wr(1, 0, 8'h00);
        wr(1, 1, 8'h80);
        setup(1, 8'h02, 8'h80, 1'b1, 1'b0);
        measure(1, 1'b1, 516);
        chk("joined high", 16'd256, 16'(hi));
        chk("even pin", 16'd0, 16'(ev));
        chk("joined zeros", 16'd2, 16'(zr));
        chk("joined max", 16'h0101, mx);
        wait_val(0, 8'h01);
        @(posedge clock_i);
        ticks_i.clk_a <= 1'b0;
        wr(2, 0, 8'h00);
        repeat (4) @(posedge clock_i);
        #1;
        chk("joined clear", 16'h0000, {channel_counter_o[0], channel_counter_o[1]});
    endtask
    // Reset for two cycles, then every scenario in turn.
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        ticks_i.clk_a <= 1'b1;
        t_left();
        t_center();
        t_bound();
        t_hold();
        t_group();
        t_join();
        final_report();
    end
endmodule // tb

// file: verilog/pwmct_pkg.sv
package pwmct_pkg;

    // Number of timer channels, and the pairs that may be joined.
    localparam int unsigned NUM_CH    = 6;
    localparam int unsigned NUM_PAIRS = 3;

    // Width of one channel's byte-wide counter, period and duty values.
    localparam int unsigned BYTE_W = 8;

    // Width of a joined channel's counter, period and duty values.
    localparam int unsigned WIDE_W = 16;

    // Reset values of the counters, the active values and the buffers.
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [7:0]  BUF_RST  = 8'h00;
    localparam logic [15:0] WIDE_RST = 16'h0000;

    // Upper byte used when a channel runs alone in byte-wide mode.
    localparam logic [7:0] HIGH_ZERO = 8'h00;

    // Step of the up/down counter.
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // Group that feeds each channel: zero means clock A/SA, one means clock B/SB.
    localparam logic [5:0] CH_GROUP_B = 6'b00_1100;

    // Count direction encodings of the center-aligned counter.
    typedef enum logic [0:0] {
        PWMCT_DIR_DOWN = 1'b0,
        PWMCT_DIR_UP   = 1'b1
    } pwmct_dir_t;

    // Per-channel control bits, one bit per channel in each field.
    typedef struct packed {
        logic [5:0] channel_enable_bit;  // Channel runs while set.
        logic [5:0] center_align_bit;    // Zero left-aligned, one center-aligned.
        logic [5:0] polarity_bit;        // One starts each period high.
        logic [5:0] clock_choice_bit;    // One selects the scaled clock.
    } pwmct_ctrl_t;

    // Pair join controls.
    typedef struct packed {
        logic join_pair_high;  // Joins channels 4 and 5.
        logic join_pair_mid;   // Joins channels 2 and 3.
        logic join_pair_low;   // Joins channels 0 and 1.
    } pwmct_join_t;

    // Software write strobes with one shared data byte.
    typedef struct packed {
        logic [5:0] period_wr;   // Writes period_value of the channel.
        logic [5:0] duty_wr;     // Writes duty_value of the channel.
        logic [5:0] counter_wr;  // Writes channel_counter of the channel.
        logic [7:0] data;        // Data byte of the write.
    } pwmct_wr_t;

    // The four prescaled clock ticks, each a one-cycle pulse.
    typedef struct packed {
        logic clk_a;   // Clock A tick.
        logic clk_sa;  // Scaled clock A tick.
        logic clk_b;   // Clock B tick.
        logic clk_sb;  // Scaled clock B tick.
    } pwmct_ticks_t;

endpackage

// file: verilog/pwmct_tick_sel.sv
`timescale 1ns/1ps
// Picks the counting tick of every channel from the four prescaled clocks.
module pwmct_tick_sel (
    input  wire pwmct_pkg::pwmct_ticks_t ticks_i,     // Prescaled clock ticks.
    input  wire logic [5:0]              choice_i,    // Per-channel clock_choice_bit.
    output logic [5:0]                   ch_tick_o    // Per-channel tick.
);

    // Decodes one channel's tick from its group and its clock choice.
    function automatic logic pick_tick(input pwmct_pkg::pwmct_ticks_t t,
                                       input logic grp_b, input logic scaled);
        logic res;
        res = grp_b ? (scaled ? t.clk_sb : t.clk_b) : (scaled ? t.clk_sa : t.clk_a);
        return res;
    endfunction

    // Channels 2 and 3 sit on the B group, the others on the A group.
    for (genvar ch = 0; ch < 6; ch++) begin : g_sel
        assign ch_tick_o[ch] = pick_tick(ticks_i, pwmct_pkg::CH_GROUP_B[ch], choice_i[ch]);
    end

endmodule // pwmct_tick_sel

// file: verilog/pwmct_top.sv
`timescale 1ns/1ps
// Function
// - Six channels, own counter, compares duty/period.
// - Duty match toggles the output flip-flop.
// - Counter readable anytime without disturbing it.
// - Counter write clears, counts up, loads.
// - Disabled channel holds count, resumes later.
// - Disabled with zero period clears on tick.
// - Enabled counter write restarts period at once.
// - Counter clears at end of period.
// - Alignment bit: zero left, one center.
// - Left: count zero to period minus one.
// - Left: frequency is clock over period.
// - Center: up/down, up whenever count zero.
// - Center: period match turns count down.
// - Center: down duty match toggles again.
// - Center: zero turns up and loads buffers.
// - Center: effective period twice period value.
// - Join bits merge pairs; even is high.
// - Joined: odd clock, polarity and pin.
// - Joined: odd enable/alignment; even pin off.
// - Either counter byte write resets joined counter.
// - Zero duty or duty>=period gives constant.
// - Zero period clears counter, constant output.
// - Polarity one starts high, else low.
// - Disabled: writes reach active values directly.

// One timer core: a 16-bit up/down counter with double-buffered values.
// Byte-wide channels feed it with a zero upper byte.
module pwmct_core (
    input  wire logic        clock_i,      // Bus clock.
    input  wire logic        rst_n_i,      // Synchronous reset, active low.
    input  wire logic        tick_i,       // Selected clock tick.
    input  wire logic        enable_i,     // Channel enable.
    input  wire logic        center_i,     // Center-aligned mode.
    input  wire logic        polarity_i,   // Polarity.
    input  wire logic [15:0] per_buf_i,    // Buffered period.
    input  wire logic [15:0] duty_buf_i,   // Buffered duty.
    input  wire logic        cnt_wr_i,     // Counter write strobe.
    output logic      [15:0] count_o,      // Current count.
    output logic             wave_o        // Waveform level.
);

    logic [15:0]           cnt_q, cnt_d;    // The counter.
    logic [15:0]           per_q, per_d;    // Active period.
    logic [15:0]           duty_q, duty_d;  // Active duty.
    pwmct_pkg::pwmct_dir_t dir_q, dir_d;    // Count direction.
    logic                  flop_q, flop_d;  // Output flip-flop.
    logic                  load;            // Loads buffers into active values.

    // Counter, direction and output flip-flop; a new period starts with flop clear.
    always_comb begin
        cnt_d  = cnt_q;
        dir_d  = dir_q;
        flop_d = flop_q;
        load   = 1'b0;
        if (!enable_i) begin
            load = 1'b1;
        end
        if (cnt_wr_i) begin
            cnt_d  = pwmct_pkg::CNT_RST;
            dir_d  = pwmct_pkg::PWMCT_DIR_UP;
            flop_d = 1'b0;
            load   = 1'b1;
        end else if (tick_i && enable_i) begin
            if (per_q == pwmct_pkg::CNT_RST) begin
                cnt_d = pwmct_pkg::CNT_RST;
            end else if (!center_i) begin
                if (cnt_q >= per_q - pwmct_pkg::CNT_STEP) begin
                    cnt_d  = pwmct_pkg::CNT_RST;
                    flop_d = 1'b0;
                    load   = 1'b1;
                end else begin
                    cnt_d = cnt_q + pwmct_pkg::CNT_STEP;
                    if (cnt_d == duty_q) begin
                        flop_d = ~flop_q;
                    end
                end
            end else begin
                if (dir_q == pwmct_pkg::PWMCT_DIR_UP && cnt_q >= per_q) begin
                    dir_d = pwmct_pkg::PWMCT_DIR_DOWN;
                    cnt_d = cnt_q - pwmct_pkg::CNT_STEP;
                end else if (dir_q == pwmct_pkg::PWMCT_DIR_UP
                             || cnt_q == pwmct_pkg::CNT_RST) begin
                    dir_d = pwmct_pkg::PWMCT_DIR_UP;
                    cnt_d = cnt_q + pwmct_pkg::CNT_STEP;
                end else begin
                    cnt_d = cnt_q - pwmct_pkg::CNT_STEP;
                end
                if (cnt_d == duty_q) begin
                    flop_d = ~flop_q;
                end
                if (dir_d == pwmct_pkg::PWMCT_DIR_DOWN && cnt_d == pwmct_pkg::CNT_RST) begin
                    dir_d  = pwmct_pkg::PWMCT_DIR_UP;
                    flop_d = 1'b0;
                    load   = 1'b1;
                end
            end
        end else if (tick_i && per_q == pwmct_pkg::CNT_RST) begin
            cnt_d = pwmct_pkg::CNT_RST;
        end
        per_d  = load ? per_buf_i : per_q;
        duty_d = load ? duty_buf_i : duty_q;
    end

    // Registers the timer state.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_q  <= pwmct_pkg::CNT_RST;
            per_q  <= pwmct_pkg::WIDE_RST;
            duty_q <= pwmct_pkg::WIDE_RST;
            dir_q  <= pwmct_pkg::PWMCT_DIR_UP;
            flop_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            duty_q <= duty_d;
            dir_q  <= dir_d;
            flop_q <= flop_d;
        end
    end

    // Boundary values override the flip-flop with a constant level.
    always_comb begin
        if (per_q == pwmct_pkg::CNT_RST) begin
            wave_o = polarity_i;
        end else if (duty_q >= per_q) begin
            wave_o = polarity_i;
        end else if (duty_q == pwmct_pkg::CNT_RST) begin
            wave_o = ~polarity_i;
        end else begin
            wave_o = polarity_i ^ flop_q;
        end
    end

    assign count_o = cnt_q;

endmodule // pwmct_core

// Six channel timers with pair joining.
module pwmct_top (
    input  wire logic                     clock_i,          // Bus clock, 200 MHz.
    input  wire logic                     rst_n_i,          // Synchronous reset, active low.
    input  wire pwmct_pkg::pwmct_ticks_t  ticks_i,          // Prescaled clock ticks.
    input  wire pwmct_pkg::pwmct_ctrl_t   ctrl_i,           // Per-channel control bits.
    input  wire pwmct_pkg::pwmct_join_t   join_i,           // Pair join controls.
    input  wire pwmct_pkg::pwmct_wr_t     wr_i,             // Software writes.
    output logic [5:0][7:0]               channel_counter_o, // Counter read-back.
    output logic [5:0]                    pwm_o             // Channel output pins.
);

    logic [5:0][7:0]  per_buf_q, per_buf_d;    // Period buffers.
    logic [5:0][7:0]  duty_buf_q, duty_buf_d;  // Duty buffers.
    logic [5:0][7:0]  rd_d;                    // Next counter read-back.
    logic [5:0]       pwm_d;                   // Next pin levels.
    logic [5:0]       ch_tick;                 // Per-channel ticks.
    logic [2:0]       joined;                  // Join bit per pair.
    logic [5:0][15:0] core_cnt;                // Core counts.
    logic [5:0]       core_wave;               // Core waveforms.

    // Join bits listed from the low pair upward.
    assign joined = {join_i.join_pair_high, join_i.join_pair_mid, join_i.join_pair_low};

    // Tick selection per channel from its own clock choice.
    pwmct_tick_sel u_tick_sel (
        .ticks_i   (ticks_i),
        .choice_i  (ctrl_i.clock_choice_bit),
        .ch_tick_o (ch_tick)
    );

    // Buffers always take software writes; the cores decide when to adopt them.
    always_comb begin
        per_buf_d  = per_buf_q;
        duty_buf_d = duty_buf_q;
        for (int ch = 0; ch < 6; ch++) begin
            if (wr_i.period_wr[ch]) begin
                per_buf_d[ch] = wr_i.data;
            end
            if (wr_i.duty_wr[ch]) begin
                duty_buf_d[ch] = wr_i.data;
            end
        end
    end

    // Registers the buffers.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            per_buf_q  <= {6{pwmct_pkg::BUF_RST}};
            duty_buf_q <= {6{pwmct_pkg::BUF_RST}};
        end else begin
            per_buf_q  <= per_buf_d;
            duty_buf_q <= duty_buf_d;
        end
    end

    // Each pair holds an even core and an odd core; when joined, the odd core runs
    // the 16-bit channel with the even bytes on top and the even core sits idle.
    for (genvar p = 0; p < 3; p++) begin : g_pair
        localparam int EV = 2 * p;
        localparam int OD = 2 * p + 1;

        logic [15:0] od_per, od_duty;  // Odd core buffered values.
        logic        od_wr, ev_wr;     // Counter writes per core.

        // Joined values concatenate the even byte above the odd byte.
        assign od_per  = joined[p] ? {per_buf_q[EV], per_buf_q[OD]}
                                   : {pwmct_pkg::HIGH_ZERO, per_buf_q[OD]};
        assign od_duty = joined[p] ? {duty_buf_q[EV], duty_buf_q[OD]}
                                   : {pwmct_pkg::HIGH_ZERO, duty_buf_q[OD]};
        // Either byte written resets the whole joined counter.
        assign od_wr = wr_i.counter_wr[OD] | (joined[p] & wr_i.counter_wr[EV]);
        assign ev_wr = wr_i.counter_wr[EV] & ~joined[p];

        // Odd core; its own control bits govern the joined channel as well.
        pwmct_core u_odd (
            .clock_i    (clock_i),
            .rst_n_i    (rst_n_i),
            .tick_i     (ch_tick[OD]),
            .enable_i   (ctrl_i.channel_enable_bit[OD]),
            .center_i   (ctrl_i.center_align_bit[OD]),
            .polarity_i (ctrl_i.polarity_bit[OD]),
            .per_buf_i  (od_per),
            .duty_buf_i (od_duty),
            .cnt_wr_i   (od_wr),
            .count_o    (core_cnt[OD]),
            .wave_o     (core_wave[OD])
        );

        // Even core; disabled while the pair is joined.
        pwmct_core u_even (
            .clock_i    (clock_i),
            .rst_n_i    (rst_n_i),
            .tick_i     (ch_tick[EV]),
            .enable_i   (ctrl_i.channel_enable_bit[EV] & ~joined[p]),
            .center_i   (ctrl_i.center_align_bit[EV]),
            .polarity_i (ctrl_i.polarity_bit[EV]),
            .per_buf_i  ({pwmct_pkg::HIGH_ZERO, per_buf_q[EV]}),
            .duty_buf_i ({pwmct_pkg::HIGH_ZERO, duty_buf_q[EV]}),
            .cnt_wr_i   (ev_wr),
            .count_o    (core_cnt[EV]),
            .wave_o     (core_wave[EV])
        );

        // Read-back and pins; both bytes of a joined count come from one cycle,
        // so a read of both in the same cycle is coherent.
        assign rd_d[OD]  = core_cnt[OD][7:0];
        assign rd_d[EV]  = joined[p] ? core_cnt[OD][15:8] : core_cnt[EV][7:0];
        assign pwm_d[OD] = core_wave[OD];
        assign pwm_d[EV] = joined[p] ? 1'b0 : core_wave[EV];
    end

    // Output registers; read-back trails the count by one cycle.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            channel_counter_o <= {6{pwmct_pkg::BUF_RST}};
            pwm_o             <= '0;
        end else begin
            channel_counter_o <= rd_d;
            pwm_o             <= pwm_d;
        end
    end

endmodule // pwmct_top
